/* File: hw/rts_sequencer.sv */
// Reset release sequencer with cause flags and an AXI4-Lite slave.
`timescale 1ns/100ps
`include "rts_cfg.svh"

module rts_sequencer
#(
    parameter int POWERUP_TIMER_CYCLES = `RTS_POWERUP_TIMER_CYCLES,
    parameter int BOR_MIN_CYCLES = `RTS_BOR_MIN_CYCLES,
    parameter int OST_TICKS = `RTS_OST_TICKS
)
(
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_POR_PULSE,
    input wire logic I_BROWNOUT_DET,
    input wire logic I_EXT_RESET_PIN_N,
    input wire logic I_OSC_TICK,
    input wire logic I_SLEEPING,
    input wire logic I_WDT_TIMEOUT,
    input wire logic I_INT_WAKE,
    input wire logic I_GLOBAL_INT_ENABLE,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [11:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [11:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_CORE_RESET,
    output logic O_RESUME,
    output logic O_INT_VECTOR,
    output logic [12:0] O_PC_TARGET,
    output logic O_IRQ
);
    import rts_pkg::*;

    localparam int PW = $clog2(POWERUP_TIMER_CYCLES + 1);
    localparam int BW = $clog2(BOR_MIN_CYCLES + 1);
    localparam int OW = $clog2(OST_TICKS + 1);
    localparam logic [PW-1:0] POWERUP_TIMER_LAST = PW'(POWERUP_TIMER_CYCLES - 1);
    localparam logic [BW-1:0] BOR_LAST = BW'(BOR_MIN_CYCLES - 1);
    localparam logic [OW-1:0] OST_LAST = OW'(OST_TICKS - 1);

    rts_state_type state;
    rts_state_type next_state;
    rts_kind_type kind;
    rts_kind_type next_kind;
    rts_cfg_type cfg;
    logic [PW-1:0] powerup_timer_cnt;
    logic [BW-1:0] bo_cnt;
    logic [OW-1:0] ost_cnt;
    logic bo_hold;
    logic pin_q;
    logic vec_pend;
    logic [7:0] stat;
    logic [1:0] power_reset_flags;
    logic [`RTS_IRQ_W-1:0] irq_stat;
    logic [`RTS_IRQ_W-1:0] irq_mask;
    logic [`RTS_IRQ_W-1:0] irq_ev;
    logic [`RTS_IRQ_W-1:0] next_irq;
    logic aw_got;
    logic w_got;
    logic [9:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic wr_fire;
    logic rd_fire;
    logic [9:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_hit;
    logic crystal;
    logic bo_low;
    logic bo_trip;
    logic hold_cond;
    logic quiet;
    logic run_ok;
    logic ev_por;
    logic ev_bor;
    logic ev_wdt_reset;
    logic ev_wdt_wake;
    logic ev_int_wake;
    logic ev_pin_fall;
    logic ev_pin_sleep;
    logic next_resume;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_wake(input rts_kind_type k);
        is_wake = (k == KIND_WAKE_WDT) || (k == KIND_WAKE_INT);
    endfunction : is_wake

    function automatic logic powerup_timer_on(input rts_kind_type k,
                                     input logic disable_cfg);
        powerup_timer_on = ((k == KIND_POWER_ON) || (k == KIND_BROWNOUT))
                  && !disable_cfg;
    endfunction : powerup_timer_on

    // Brown-out is a power-up path, so it also gets the start-up count
    function automatic logic ost_on(input rts_kind_type k, input logic xtal);
        ost_on = xtal && (k != KIND_WDT) && (k != KIND_PIN);
    endfunction : ost_on

    function automatic logic reg_known(input logic [9:0] idx);
        reg_known = (idx == `RTS_IDX_STATUS) || (idx == `RTS_IDX_POWER_RESET_FLAGS)
                    || (idx == `RTS_IDX_CFG) || (idx == `RTS_IDX_IRQ_STAT)
                    || (idx == `RTS_IDX_IRQ_MASK);
    endfunction : reg_known

    // ------------------------------------------------------------------
    // Reset causes
    // ------------------------------------------------------------------
    assign crystal = cfg.osc_mode != OSC_RESISTOR_CAP;
    assign bo_low = cfg.brownout_enable_cfg && I_BROWNOUT_DET;
    assign bo_trip = bo_low && !bo_hold && (bo_cnt == BOR_LAST);
    assign hold_cond = I_POR_PULSE || bo_hold || bo_low;
    assign quiet = !I_POR_PULSE && !bo_trip;
    assign run_ok = quiet && (state == ST_RUN);
    assign ev_por = I_POR_PULSE;
    assign ev_bor = !I_POR_PULSE && bo_trip;
    assign ev_wdt_reset = run_ok && I_WDT_TIMEOUT && !I_SLEEPING;
    assign ev_wdt_wake = run_ok && I_WDT_TIMEOUT && I_SLEEPING;
    assign ev_int_wake = run_ok && !I_WDT_TIMEOUT && I_INT_WAKE && I_SLEEPING;
    assign ev_pin_fall = quiet && pin_q && !I_EXT_RESET_PIN_N;
    assign ev_pin_sleep = ev_pin_fall && I_SLEEPING && (state == ST_RUN);

    // Dip filter: count only while the dip persists
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            bo_cnt <= '0;
            bo_hold <= 1'b0;
        end
        else
        begin
            if (!bo_low)
                bo_cnt <= '0;
            else if (bo_cnt != BOR_LAST)
                bo_cnt <= bo_cnt + 1'b1;
            if (bo_trip)
                bo_hold <= 1'b1;
            else if (!bo_low)
                bo_hold <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_kind = kind;
        if (ev_por)
        begin
            next_state = ST_HOLD;
            next_kind = KIND_POWER_ON;
        end
        else if (ev_bor)
        begin
            next_state = ST_HOLD;
            next_kind = KIND_BROWNOUT;
        end
        else
        begin
            unique case (state)
                ST_HOLD:
                    if (!hold_cond)
                    begin
                        if (powerup_timer_on(kind, cfg.powerup_timer_disable_cfg))
                            next_state = ST_POWERUP_TIMER;
                        else if (ost_on(kind, crystal))
                            next_state = ST_OST;
                        else
                            next_state = ST_RUN;
                    end
                ST_POWERUP_TIMER:
                    if (powerup_timer_cnt == POWERUP_TIMER_LAST)
                        next_state = ost_on(kind, crystal) ? ST_OST : ST_RUN;
                ST_OST:
                    if (I_OSC_TICK && (ost_cnt == OST_LAST))
                        next_state = ST_RUN;
                ST_RUN:
                    if (ev_wdt_reset)
                    begin
                        next_state = ST_HOLD;
                        next_kind = KIND_WDT;
                    end
                    else if (ev_wdt_wake || ev_int_wake)
                    begin
                        next_kind = ev_wdt_wake ? KIND_WAKE_WDT
                                                : KIND_WAKE_INT;
                        next_state = ost_on(next_kind, crystal)
                                     ? ST_OST : ST_RUN;
                    end
                    else if (ev_pin_fall)
                        next_kind = KIND_PIN;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state <= ST_HOLD;
            kind <= KIND_POWER_ON;
        end
        else
        begin
            state <= next_state;
            kind <= next_kind;
        end
    end

    // Timers restart whenever their state is entered afresh
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            powerup_timer_cnt <= '0;
            ost_cnt <= '0;
        end
        else
        begin
            if ((state == ST_POWERUP_TIMER) && (next_state == ST_POWERUP_TIMER))
                powerup_timer_cnt <= powerup_timer_cnt + 1'b1;
            else
                powerup_timer_cnt <= '0;
            if ((state == ST_OST) && (next_state == ST_OST))
                ost_cnt <= ost_cnt + OW'(I_OSC_TICK);
            else
                ost_cnt <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Core control outputs
    // ------------------------------------------------------------------
    assign next_resume = is_wake(next_kind) && (next_state == ST_RUN)
                         && ((state == ST_OST) || ev_wdt_wake || ev_int_wake);

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_CORE_RESET <= 1'b1;
            O_RESUME <= 1'b0;
            O_INT_VECTOR <= 1'b0;
            O_PC_TARGET <= `RTS_VEC_RESET;
            vec_pend <= 1'b0;
            pin_q <= 1'b1;
        end
        else
        begin
            pin_q <= I_EXT_RESET_PIN_N;
            // Pin only gates the core; timers run on regardless
            O_CORE_RESET <= ((next_state != ST_RUN) && !is_wake(next_kind))
                            || !I_EXT_RESET_PIN_N;
            O_RESUME <= next_resume;
            // Enable is taken at the wake itself; a stale pending bit
            // must never vector a later watchdog wake
            O_INT_VECTOR <= next_resume && (ev_int_wake
                            ? I_GLOBAL_INT_ENABLE
                            : (vec_pend && !ev_wdt_wake));
            if (ev_int_wake)
                vec_pend <= I_GLOBAL_INT_ENABLE && !next_resume;
            else if (ev_wdt_wake || next_resume)
                vec_pend <= 1'b0;
            if (ev_int_wake && I_GLOBAL_INT_ENABLE)
                O_PC_TARGET <= `RTS_VEC_INT;
            else if (ev_por || ev_bor || ev_wdt_reset || ev_pin_fall)
                O_PC_TARGET <= `RTS_VEC_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            stat <= `RTS_STATUS_RESET;
        else if (ev_por)
            stat <= `RTS_STATUS_RESET;
        else if (ev_bor)
            stat <= {3'h0, 2'h3, stat[2:0]};
        else if (ev_wdt_reset)
            stat <= {4'h0, stat[3:0]};
        else if (ev_wdt_wake)
            stat <= {stat[7:5], 2'h0, stat[2:0]};
        else if (ev_int_wake)
            stat <= {stat[7:5], 2'h2, stat[2:0]};
        else if (ev_pin_sleep)
            stat <= {3'h0, 2'h2, stat[2:0]};
        else if (ev_pin_fall)
            stat <= {3'h0, stat[4:0]};
        else if (wr_fire && wr_lane && (wr_idx == `RTS_IDX_STATUS))
            stat <= {wr_byte[7:5], stat[4:3], wr_byte[2:0]};
    end

    // Hardware clear beats a same-cycle software write, bit by bit
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            power_reset_flags <= `RTS_POWER_RESET_FLAGS_RESET;
        else
        begin
            if (ev_por)
                power_reset_flags[`RTS_POWER_RESET_FLAGS_POR_BIT] <= 1'b0;
            else if (wr_fire && wr_lane && (wr_idx == `RTS_IDX_POWER_RESET_FLAGS))
                power_reset_flags[`RTS_POWER_RESET_FLAGS_POR_BIT] <= wr_byte[`RTS_POWER_RESET_FLAGS_POR_BIT];
            if (ev_bor)
                power_reset_flags[`RTS_POWER_RESET_FLAGS_BOR_BIT] <= 1'b0;
            else if (wr_fire && wr_lane && (wr_idx == `RTS_IDX_POWER_RESET_FLAGS))
                power_reset_flags[`RTS_POWER_RESET_FLAGS_BOR_BIT] <= wr_byte[`RTS_POWER_RESET_FLAGS_BOR_BIT];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            cfg <= `RTS_CFG_RESET;
        else if (wr_fire && wr_lane && (wr_idx == `RTS_IDX_CFG))
            cfg <= wr_byte[3:0];
    end

    // ------------------------------------------------------------------
    // Interrupts: sticky, cleared by reading, new events win
    // ------------------------------------------------------------------
    assign irq_ev = {ev_wdt_wake || ev_int_wake, ev_pin_fall,
                     ev_wdt_reset, ev_bor};
    assign next_irq = (irq_stat & ~{`RTS_IRQ_W{rd_fire
                      && (rd_idx == `RTS_IDX_IRQ_STAT)}}) | irq_ev;

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
            O_IRQ <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq;
            if (wr_fire && wr_lane && (wr_idx == `RTS_IDX_IRQ_MASK))
                irq_mask <= wr_byte[`RTS_IRQ_W-1:0];
            O_IRQ <= |(next_irq & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign wr_fire = aw_got && w_got && !O_BVALID;
    assign rd_fire = I_ARVALID && O_ARREADY;
    assign rd_idx = I_ARADDR[11:2];

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_idx <= '0;
            wr_byte <= '0;
            wr_lane <= 1'b0;
            O_AWREADY <= 1'b1;
            O_WREADY <= 1'b1;
            O_BVALID <= 1'b0;
            O_BRESP <= `RTS_RESP_OKAY;
        end
        else
        begin
            if (I_AWVALID && O_AWREADY)
            begin
                aw_got <= 1'b1;
                O_AWREADY <= 1'b0;
                wr_idx <= I_AWADDR[11:2];
            end
            if (I_WVALID && O_WREADY)
            begin
                w_got <= 1'b1;
                O_WREADY <= 1'b0;
                wr_byte <= I_WDATA[7:0];
                wr_lane <= I_WSTRB[0];
            end
            if (wr_fire)
            begin
                O_BVALID <= 1'b1;
                O_BRESP <= reg_known(wr_idx) ? `RTS_RESP_OKAY
                                             : `RTS_RESP_SLVERR;
            end
            else if (O_BVALID && I_BREADY)
            begin
                O_BVALID <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                O_AWREADY <= 1'b1;
                O_WREADY <= 1'b1;
            end
        end
    end

    always_comb
    begin
        rd_data = '0;
        rd_hit = reg_known(rd_idx);
        if (rd_idx == `RTS_IDX_STATUS)
            rd_data[7:0] = stat;
        else if (rd_idx == `RTS_IDX_POWER_RESET_FLAGS)
            rd_data[1:0] = power_reset_flags;
        else if (rd_idx == `RTS_IDX_CFG)
            rd_data[3:0] = cfg;
        else if (rd_idx == `RTS_IDX_IRQ_STAT)
            rd_data[`RTS_IRQ_W-1:0] = irq_stat;
        else if (rd_idx == `RTS_IDX_IRQ_MASK)
            rd_data[`RTS_IRQ_W-1:0] = irq_mask;
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_ARREADY <= 1'b1;
            O_RVALID <= 1'b0;
            O_RDATA <= '0;
            O_RRESP <= `RTS_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b1;
            O_RDATA <= rd_data;
            O_RRESP <= rd_hit ? `RTS_RESP_OKAY : `RTS_RESP_SLVERR;
        end
        else if (O_RVALID && I_RREADY)
        begin
            O_RVALID <= 1'b0;
            O_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    sequence powerup_timer_ends_s;
        (state == ST_POWERUP_TIMER) && (next_state != ST_POWERUP_TIMER) && quiet;
    endsequence

    sequence ost_ends_s;
        (state == ST_OST) && (next_state == ST_RUN) && quiet;
    endsequence

    ost_count_a: assert property (ost_ends_s |->
        I_OSC_TICK && (ost_cnt == OST_LAST))
        else $error("start-up count ended early");
    ost_gate_a: assert property ($rose(state == ST_OST) |->
        $past(crystal) && !$past(next_kind == KIND_WDT))
        else $error("start-up count in wrong mode");
    bo_disabled_a: assert property (!cfg.brownout_enable_cfg |->
        !bo_trip ##1 !bo_hold)
        else $error("brown-out acted while disabled");
    bo_filter_a: assert property (bo_trip |->
        I_BROWNOUT_DET && (bo_cnt == BOR_LAST))
        else $error("brown-out dip filter bypassed");
    powerup_timer_length_a: assert property (powerup_timer_ends_s |->
        powerup_timer_cnt == POWERUP_TIMER_LAST)
        else $error("power-up timer wrong length");
    bo_restart_a: assert property (((state == ST_POWERUP_TIMER) && ev_bor) |=>
        (state == ST_HOLD) && (kind == KIND_BROWNOUT) && (powerup_timer_cnt == 0))
        else $error("brown-out did not restart timer");
    order_first_a: assert property (((state == ST_HOLD)
        && (next_state == ST_OST)) |-> !powerup_timer_on(kind,
        cfg.powerup_timer_disable_cfg))
        else $error("start-up count before power-up timer");
    rc_nowait_a: assert property (((state == ST_HOLD) && !hold_cond
        && !crystal && cfg.powerup_timer_disable_cfg) |=>
        (state == ST_RUN))
        else $error("RC mode waited with timer off");
    pin_release_a: assert property (((state == ST_RUN)
        && !is_wake(kind) && I_EXT_RESET_PIN_N && quiet
        && !I_WDT_TIMEOUT) |=> !O_CORE_RESET)
        else $error("reset not released on pin rise");
    bor_flag_a: assert property (ev_bor |=>
        !power_reset_flags[`RTS_POWER_RESET_FLAGS_BOR_BIT] && stat[4:3] == 2'h3)
        else $error("brown-out flag not cleared");
    por_flag_a: assert property (ev_por |=>
        !power_reset_flags[`RTS_POWER_RESET_FLAGS_POR_BIT] && (stat == `RTS_STATUS_RESET))
        else $error("power-on flags wrong");
    wdt_flags_a: assert property (ev_wdt_reset |=>
        !stat[`RTS_STAT_TO_BIT] && (stat[3] == $past(stat[3])))
        else $error("watchdog reset flags wrong");
    wake_vector_a: assert property ((ev_int_wake && I_GLOBAL_INT_ENABLE)
        |=> (O_PC_TARGET == `RTS_VEC_INT))
        else $error("interrupt vector not set");
    wake_status_a: assert property (ev_wdt_wake |=>
        (stat[4:3] == 2'h0) && (stat[7:5] == $past(stat[7:5])))
        else $error("watchdog wake status wrong");
    hold_reset_a: assert property ((state inside {ST_HOLD, ST_POWERUP_TIMER}
        && !is_wake(kind)) |-> O_CORE_RESET)
        else $error("core left reset too soon");

endmodule : rts_sequencer

/* File: shared/rts_cfg.svh */
// Constants for the reset timeout sequencer.
`ifndef RTS_CFG_SVH
`define RTS_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTS_CLK_PERIOD_NS 25
`define RTS_POWERUP_TIMER_TIME_NS 72000000
`define RTS_POWERUP_TIMER_CYCLES (`RTS_POWERUP_TIMER_TIME_NS / `RTS_CLK_PERIOD_NS)
`define RTS_BOR_MIN_TIME_NS 100000
`define RTS_BOR_MIN_CYCLES \
    ((`RTS_BOR_MIN_TIME_NS + `RTS_CLK_PERIOD_NS - 1) / `RTS_CLK_PERIOD_NS)
`define RTS_OST_TICKS 1024

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RTS_IDX_STATUS 10'h003
`define RTS_IDX_POWER_RESET_FLAGS 10'h08E
`define RTS_IDX_CFG 10'h0A0
`define RTS_IDX_IRQ_STAT 10'h0A1
`define RTS_IDX_IRQ_MASK 10'h0A2

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define RTS_STAT_TO_BIT 4
`define RTS_STAT_PD_BIT 3
`define RTS_POWER_RESET_FLAGS_BOR_BIT 0
`define RTS_POWER_RESET_FLAGS_POR_BIT 1
`define RTS_STATUS_RESET 8'h18
`define RTS_POWER_RESET_FLAGS_RESET 2'h0
`define RTS_CFG_RESET 4'hC
`define RTS_IRQ_W 4
`define RTS_VEC_RESET 13'h0000
`define RTS_VEC_INT 13'h0004
`define RTS_RESP_OKAY 2'h0
`define RTS_RESP_SLVERR 2'h2

`endif

/* File: shared/rts_pkg.sv */
// Types shared by the reset timeout sequencer.
package rts_pkg;

    typedef enum logic [1:0] {
        OSC_LOW_POWER_CRYSTAL,
        OSC_CRYSTAL,
        OSC_HIGH_SPEED_CRYSTAL,
        OSC_RESISTOR_CAP
    } rts_osc_type;

    typedef enum logic [2:0] {
        KIND_POWER_ON,
        KIND_BROWNOUT,
        KIND_WDT,
        KIND_PIN,
        KIND_WAKE_WDT,
        KIND_WAKE_INT
    } rts_kind_type;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_POWERUP_TIMER,
        ST_OST,
        ST_RUN
    } rts_state_type;

    // Configuration word layout, MSB first
    typedef struct packed {
        rts_osc_type osc_mode;
        logic powerup_timer_disable_cfg;
        logic brownout_enable_cfg;
    } rts_cfg_type;

endpackage : rts_pkg

/* File: tb/rts_supply_model.sv */
// Supply monitor, reset pin and oscillator stand-in for the sequencer.
`timescale 1ns/100ps
module rts_supply_model
(
    input wire logic i_clk,
    input wire logic i_por,
    input wire logic i_low,
    input wire logic i_pin_low,
    output logic o_por_pulse,
    output logic o_brownout_det,
    output logic o_pin_n,
    output logic o_osc_tick
);
    logic [1:0] div = 2'h0;
    initial
    begin
        o_por_pulse = 1'b0;
        o_brownout_det = 1'b0;
        o_pin_n = 1'b1;
        o_osc_tick = 1'b0;
    end
    // Crystal keeps running; one tick every four clocks
    always @(posedge i_clk)
    begin
        div <= div + 2'h1;
        o_osc_tick <= (div == 2'h3);
        o_por_pulse <= i_por;
        o_brownout_det <= i_low;
        o_pin_n <= !i_pin_low;
    end
endmodule : rts_supply_model

/* File: tb/rts_sequencer_test.sv */
// Self-checking bench for the reset timeout sequencer.
`timescale 1ns/100ps
module rts_sequencer_test;
    import rts_pkg::*;
    int mismatches = 0;
    int n_compared = 0;
    int n;
    logic I_CLK = 1'b0, I_RST_B = 1'b0, por = 1'b0, low = 1'b0, pin_low = 1'b0;
    logic I_POR_PULSE, I_BROWNOUT_DET, I_EXT_RESET_PIN_N, I_OSC_TICK;
    logic I_SLEEPING = 1'b0, I_WDT_TIMEOUT = 1'b0, I_INT_WAKE = 1'b0;
    logic I_GLOBAL_INT_ENABLE = 1'b0;
    logic [3:0] I_WSTRB = 4'hF;
    logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0;
    logic I_ARVALID = 1'b0, I_RREADY = 1'b0;
    logic [11:0] I_AWADDR = 12'h000, I_ARADDR = 12'h000;
    logic [31:0] I_WDATA = 32'h0, O_RDATA, rd;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    logic O_CORE_RESET, O_IRQ, O_RESUME, O_INT_VECTOR;
    logic [1:0] O_BRESP, O_RRESP, rr;
    logic [12:0] O_PC_TARGET;

    always #12.5 I_CLK = ~I_CLK;

    rts_supply_model model (.i_clk(I_CLK), .i_por(por), .i_low(low),
        .i_pin_low(pin_low), .o_por_pulse(I_POR_PULSE),
        .o_brownout_det(I_BROWNOUT_DET), .o_pin_n(I_EXT_RESET_PIN_N),
        .o_osc_tick(I_OSC_TICK));
    rts_sequencer #(.POWERUP_TIMER_CYCLES(20), .BOR_MIN_CYCLES(4), .OST_TICKS(8))
        dut (.*);

    task automatic tally_and_finish;
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic hang;
        chk(32'h0, 32'h1);
        tally_and_finish();
    endtask : hang

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        I_AWADDR <= a;
        I_WDATA <= {24'h0, d};
        I_AWVALID <= 1'b1;
        I_WVALID <= 1'b1;
        I_BREADY <= 1'b1;
        for (int k = 0; k <= 50; k++)
        begin
            @(posedge I_CLK);
            if (O_AWREADY) I_AWVALID <= 1'b0;
            if (O_WREADY) I_WVALID <= 1'b0;
            if (O_BVALID) break;
            if (k == 50) hang();
        end
        I_BREADY <= 1'b0;
        @(posedge I_CLK);
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        I_RREADY <= 1'b1;
        for (int k = 0; k <= 50; k++)
        begin
            @(posedge I_CLK);
            if (O_ARREADY) I_ARVALID <= 1'b0;
            if (O_RVALID) break;
            if (k == 50) hang();
        end
        rd = O_RDATA;
        rr = O_RRESP;
        I_RREADY <= 1'b0;
        @(posedge I_CLK);
    endtask : rdr

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask : rc

    // Cycles from now until the core leaves reset, bounded
    task automatic rel;
        n = 0;
        while (O_CORE_RESET !== 1'b0)
        begin
            @(posedge I_CLK);
            n++;
            if (n > 2000) hang();
        end
    endtask : rel

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_power;
        rel();
        chk(n >= 20 && n <= 26, 32'h1);
        chk(O_PC_TARGET, 13'h0000);
        rc(12'h00C, 32'h18);
        rc(12'h238, 32'h0);
    endtask : s_power

    task automatic s_brown;
        wr(12'h238, 8'h03);
        rc(12'h238, 32'h3);
        wr(12'h280, 8'h05);
        wr(12'h288, 8'h01);
        low <= 1'b1;
        repeat (2) @(posedge I_CLK);
        low <= 1'b0;
        repeat (8) @(posedge I_CLK);
        chk(O_CORE_RESET, 32'h0);
        low <= 1'b1;
        repeat (10) @(posedge I_CLK);
        chk(O_CORE_RESET, 32'h1);
        chk(O_IRQ, 32'h1);
        low <= 1'b0;
        rel();
        chk(n >= 50 && n <= 62, 32'h1);
        rc(12'h238, 32'h2);
        rc(12'h284, 32'h1);
        chk(O_IRQ, 32'h0);
    endtask : s_brown

    task automatic s_pin;
        wr(12'h280, 8'h0E);
        pin_low <= 1'b1;
        por <= 1'b1;
        repeat (4) @(posedge I_CLK);
        por <= 1'b0;
        repeat (40) @(posedge I_CLK);
        chk(O_CORE_RESET, 32'h1);
        pin_low <= 1'b0;
        rel();
        chk(n <= 4, 32'h1);
        rc(12'h238, 32'h0);
    endtask : s_pin

    task automatic s_wake;
        I_SLEEPING <= 1'b1;
        I_GLOBAL_INT_ENABLE <= 1'b1;
        I_INT_WAKE <= 1'b1;
        @(posedge I_CLK);
        I_INT_WAKE <= 1'b0;
        @(negedge I_CLK);
        chk(O_RESUME, 32'h1);
        chk(O_INT_VECTOR, 32'h1);
        chk(O_PC_TARGET, 32'h4);
        rc(12'h00C, 32'h10);
        I_WDT_TIMEOUT <= 1'b1;
        @(posedge I_CLK);
        I_WDT_TIMEOUT <= 1'b0;
        @(negedge I_CLK);
        chk(O_RESUME, 32'h1);
        chk(O_INT_VECTOR, 32'h0);
        rc(12'h00C, 32'h0);
        wr(12'h00C, 8'hE5);
        I_SLEEPING <= 1'b0;
        I_WDT_TIMEOUT <= 1'b1;
        @(posedge I_CLK);
        I_WDT_TIMEOUT <= 1'b0;
        @(negedge I_CLK);
        chk(O_CORE_RESET, 32'h1);
        chk(O_PC_TARGET, 32'h0);
        rel();
        rc(12'h00C, 32'h05);
    endtask : s_wake

    task automatic s_unmapped;
        rc(12'h100, 32'h0);
        chk(rr, 32'h2);
    endtask : s_unmapped

    initial
    begin
        repeat (2) @(posedge I_CLK);
        I_RST_B <= 1'b1;
        s_power();
        s_brown();
        s_pin();
        s_wake();
        s_unmapped();
        tally_and_finish();
    end
endmodule : rts_sequencer_test
